// file: hdl/arc_params.svh
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ARC_OFF_RESULT_LOW  12'h000
`define ARC_OFF_RESULT_HIGH 12'h004
`define ARC_OFF_CHREF       12'h008
`define ARC_OFF_CTRL_A      12'h00C
`define ARC_OFF_CTRL_B      12'h010
`define ARC_OFF_MISC        12'h014
`define ARC_OFF_SIG_ADDR    12'h018
`define ARC_OFF_SIG_DATA    12'h01C
`define ARC_OFF_CONV_CODE   12'h020
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ARC_CTRLA_EN        7
`define ARC_CTRLA_START     6
`define ARC_CTRLA_DONE      4
`define ARC_CTRLB_BIPOLAR   7
`define ARC_MISC_REF_OUTPUT_ENABLE     1
`define ARC_MISC_EXTREF     0
`define ARC_CHREF_LEFT      5
// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define ARC_CH_TEMP         5'h0B
`define ARC_SIG_GAIN_ADDR   16'h0005
`define ARC_SIG_OFFS_ADDR   16'h0003
`define ARC_GAIN_CAL_RST    8'h80
`define ARC_OFFS_CAL_RST    8'h00
`define ARC_CONV_CYCLES     4'hD
`define ARC_CODE_MAX        10'h3FF
`define ARC_BIP_MAX         10'h1FF
`define ARC_BIP_MIN         10'h200
`endif

// file: hdl/arc_pkg.sv
package arc_pkg;
   typedef enum logic [1:0] {
      ARC_REF_AVCC  = 2'b00,
      ARC_REF_1V1   = 2'b01,
      ARC_REF_2V56  = 2'b11,
      ARC_REF_EXT   = 2'b10
   } arc_ref_t;
   typedef enum logic [1:0] {
      ARC_ST_IDLE = 2'b00,
      ARC_ST_CONV = 2'b01,
      ARC_ST_DONE = 2'b10
   } arc_state_t;
endpackage : arc_pkg

// file: hdl/arc_result_ctrl.sv
`timescale 1ns/1ns
`include "arc_params.svh"
// Functional notes
// - result stays in low/high registers after done
// - single-ended: unsigned code, vin*1024/vref
// - unipolar differential: unsigned, times gain
// - unipolar negative difference saturates to zero
// - unipolar default; bipolar select bit switches
// - bipolar: two's complement 0x200..0x1FF
// - differential gain eight or twenty by code
// - gain cal at 0x0005, offset at 0x0003
// - gain cal unsigned, step 1/128
// - offset cal signed two's complement
// - reference pin hi-z unless enabled; 1.1/2.56
// - reference pin driven only while converter on
// - completion writes result, sets done flag
// - channel code 0_1011 selects temperature sensor
// - ref code 01, ext-ref clear selects 1.1 V
module arc_result_ctrl #(
   parameter int CONV_CYCLES = `ARC_CONV_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // analog front end: signed difference, in steps of vref/1024
   input  wire logic [11:0] afe_sample,
   input  wire logic [7:0]  fuse_gain_cal,
   input  wire logic [7:0]  fuse_offset_cal,
   // reference output pin and analog selects
   output logic             ref_output_pin_oe,
   output logic [1:0]       ref_output_level,
   output logic             temp_sensor_sel,
   output logic             ref_internal_1v1
);
   import arc_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  channel_ref_select_reg;
   logic        conv_enable_reg;
   logic        conv_start_reg;
   logic        conv_done_flag;
   logic        bipolar_select;
   logic        ref_output_enable;
   logic        ext_ref_enable;
   logic [9:0]  result_reg;
   logic [9:0]  result_next;
   logic [15:0] sig_addr_reg;
   logic [3:0]  conv_cnt_reg;
   logic [4:0]  chan_lock_reg;
   logic [11:0] afe_s1_reg;
   logic [11:0] afe_s2_reg;
   arc_state_t  state_reg;

   logic        wr_acc;
   logic        rd_acc;
   logic        done_clr;
   logic        finish;
   logic [4:0]  channel_select;
   logic [1:0]  ref_sel;

   assign channel_select = channel_ref_select_reg[4:0];
   assign ref_sel        = channel_ref_select_reg[7:6];
   assign wr_acc         = psel && penable && pwrite;
   assign rd_acc         = psel && !penable && !pwrite;
   assign finish         = (state_reg == ARC_ST_CONV) && (conv_cnt_reg == 4'h0);
   assign done_clr       = wr_acc && (paddr == `ARC_OFF_CTRL_A)
                           && pwdata[`ARC_CTRLA_DONE];

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // differential codes use odd/even lsb for 20x / 8x gain
   function automatic logic is_diff(input logic [4:0] ch);
      is_diff = ch[4];
   endfunction : is_diff

   function automatic logic [11:0] clip_code(input logic signed [15:0] v,
                                             input logic               bip);
      logic signed [15:0] hi;
      logic signed [15:0] lo;
      hi = bip ? 16'sh01FF : 16'sh03FF;
      lo = bip ? -16'sh0200 : 16'sh0000;
      if (v > hi) begin
         clip_code = hi[11:0];
      end else if (v < lo) begin
         clip_code = lo[11:0];
      end else begin
         clip_code = v[11:0];
      end
   endfunction : clip_code

   // ----------------------------------------------------------------
   // pin sync for the analog sample word
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         afe_s1_reg <= 12'h000;
         afe_s2_reg <= 12'h000;
      end else begin
         afe_s1_reg <= afe_sample;
         afe_s2_reg <= afe_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // result coding
   // ----------------------------------------------------------------
   always_comb begin
      logic signed [15:0] diff;
      logic signed [15:0] scaled;
      logic [11:0]        c;
      diff   = {{4{afe_s2_reg[11]}}, afe_s2_reg};
      // clamp first: a full-scale sample times 20 would overflow 16 bits
      if (diff > 16'sd1023) begin
         diff = 16'sd1023;
      end else if (diff < -16'sd1024) begin
         diff = -16'sd1024;
      end
      scaled = diff;
      c      = 12'h000;
      if (!is_diff(chan_lock_reg)) begin
         if (diff < 0) begin
            scaled = 16'sh0000;
         end
         c = clip_code(scaled, 1'b0);
      end else begin
         scaled = chan_lock_reg[0] ? 16'(diff * 20) : 16'(diff * 8);
         if (bipolar_select) begin
            c = clip_code(16'(scaled >>> 1), 1'b1);
         end else begin
            c = clip_code(scaled, 1'b0);
         end
      end
      result_next = c[9:0];
   end

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ARC_ST_IDLE;
         conv_cnt_reg <= 4'h0;
         chan_lock_reg <= 5'h00;
      end else if (!conv_enable_reg) begin
         state_reg    <= ARC_ST_IDLE;
      end else begin
         case (state_reg)
            ARC_ST_IDLE: begin
               chan_lock_reg <= channel_select;
               if (conv_start_reg) begin
                  state_reg    <= ARC_ST_CONV;
                  conv_cnt_reg <= 4'(CONV_CYCLES - 1);
               end
            end
            ARC_ST_CONV: begin
               if (finish) begin
                  state_reg <= ARC_ST_DONE;
               end else begin
                  conv_cnt_reg <= conv_cnt_reg - 4'h1;
               end
            end
            ARC_ST_DONE: begin
               state_reg <= ARC_ST_IDLE;
            end
            default: begin
               state_reg <= ARC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= 10'h000;
      end else if (finish && conv_enable_reg) begin
         result_reg <= result_next;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done_flag <= 1'b0;
      end else if (finish && conv_enable_reg) begin
         conv_done_flag <= 1'b1;
      end else if (done_clr) begin
         conv_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start_reg <= 1'b0;
      end else if (!conv_enable_reg || finish) begin
         conv_start_reg <= 1'b0;
      end else if (wr_acc && paddr == `ARC_OFF_CTRL_A && pwdata[`ARC_CTRLA_START]) begin
         conv_start_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_ref_select_reg <= 8'h00;
         conv_enable_reg        <= 1'b0;
         bipolar_select         <= 1'b0;
         ref_output_enable      <= 1'b0;
         ext_ref_enable         <= 1'b0;
         sig_addr_reg           <= 16'h0000;
      end else if (wr_acc) begin
         case (paddr)
            `ARC_OFF_CHREF:    channel_ref_select_reg <= pwdata[7:0];
            `ARC_OFF_CTRL_A:   conv_enable_reg <= pwdata[`ARC_CTRLA_EN];
            `ARC_OFF_CTRL_B:   bipolar_select <= pwdata[`ARC_CTRLB_BIPOLAR];
            `ARC_OFF_MISC: begin
               ref_output_enable <= pwdata[`ARC_MISC_REF_OUTPUT_ENABLE];
               ext_ref_enable    <= pwdata[`ARC_MISC_EXTREF];
            end
            `ARC_OFF_SIG_ADDR: sig_addr_reg <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // apb read path
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (rd_acc) begin
         pslverr <= 1'b0;
         case (paddr)
            `ARC_OFF_RESULT_LOW: begin
               prdata <= channel_ref_select_reg[`ARC_CHREF_LEFT] ?
                         {24'h00_0000, result_reg[1:0], 6'h00} :
                         {24'h00_0000, result_reg[7:0]};
            end
            `ARC_OFF_RESULT_HIGH: begin
               prdata <= channel_ref_select_reg[`ARC_CHREF_LEFT] ?
                         {24'h00_0000, result_reg[9:2]} :
                         {30'h0000_0000, result_reg[9:8]};
            end
            `ARC_OFF_CHREF:  prdata <= {24'h00_0000, channel_ref_select_reg};
            `ARC_OFF_CTRL_A: prdata <= {24'h00_0000, conv_enable_reg,
                                        conv_start_reg, 1'b0, conv_done_flag, 4'h0};
            `ARC_OFF_CTRL_B: prdata <= {24'h00_0000, bipolar_select, 7'h00};
            `ARC_OFF_MISC:   prdata <= {30'h0000_0000, ref_output_enable,
                                        ext_ref_enable};
            `ARC_OFF_SIG_ADDR: prdata <= {16'h0000, sig_addr_reg};
            `ARC_OFF_SIG_DATA: begin
               if (sig_addr_reg == `ARC_SIG_GAIN_ADDR) begin
                  prdata <= {24'h00_0000, fuse_gain_cal};
               end else if (sig_addr_reg == `ARC_SIG_OFFS_ADDR) begin
                  prdata <= {24'h00_0000, fuse_offset_cal};
               end else begin
                  prdata <= 32'h0000_0000;
               end
            end
            `ARC_OFF_CONV_CODE: prdata <= {22'h00_0000, result_next};
            default: begin
               prdata  <= 32'h0000_0000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   // ----------------------------------------------------------------
   // reference output and analog selects
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_output_pin_oe <= 1'b0;
         ref_output_level  <= 2'b00;
         temp_sensor_sel   <= 1'b0;
         ref_internal_1v1  <= 1'b0;
      end else begin
         // 1.1 V and 2.56 V both set select bit 0 and drive the pin when enabled, converter on and ext-ref clear; other codes leave the pin floating
         ref_output_pin_oe <= ref_output_enable && conv_enable_reg
                              && ref_sel[0] && !ext_ref_enable;
         ref_output_level  <= ref_sel;
         temp_sensor_sel   <= (chan_lock_reg == `ARC_CH_TEMP);
         ref_internal_1v1  <= (ref_sel == ARC_REF_1V1) && !ext_ref_enable;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pin_off_when_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !(ref_output_enable && conv_enable_reg) |=> !ref_output_pin_oe)
      else $error("reference pin driven while disabled");
   a_done_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (finish && conv_enable_reg) |=> conv_done_flag)
      else $error("done flag not set at finish");
   a_result_held: assert property (@(posedge pclk) disable iff (!presetn)
      !(finish && conv_enable_reg) |=> $stable(result_reg))
      else $error("result changed without a finish");
   a_bipolar_default: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && paddr == `ARC_OFF_CTRL_B) |=> $stable(bipolar_select))
      else $error("bipolar select changed without a write");
   a_uni_range: assert property (@(posedge pclk) disable iff (!presetn)
      (is_diff(chan_lock_reg) && !bipolar_select && $signed(afe_s2_reg) < 0)
      |-> result_next == 10'h000)
      else $error("unipolar negative did not saturate to zero");
   a_bip_clip: assert property (@(posedge pclk) disable iff (!presetn)
      (is_diff(chan_lock_reg) && bipolar_select && $signed(afe_s2_reg) > 12'sd127)
      |-> result_next == `ARC_BIP_MAX)
      else $error("bipolar positive overflow not clipped");
   a_single_max: assert property (@(posedge pclk) disable iff (!presetn)
      (!is_diff(chan_lock_reg) && $signed(afe_s2_reg) > 12'sd1023)
      |-> result_next == `ARC_CODE_MAX)
      else $error("single-ended overflow not clipped");
   a_temp_select: assert property (@(posedge pclk) disable iff (!presetn)
      (chan_lock_reg == `ARC_CH_TEMP) |=> temp_sensor_sel)
      else $error("temperature sensor not selected");

endmodule : arc_result_ctrl

// file: tb/arc_afe_model.sv
`timescale 1ns/1ns
module arc_afe_model #(
   parameter logic [7:0] GAIN_CAL = 8'h7a,
   parameter logic [7:0] OFFS_CAL = 8'hf3
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // level asked for by the bench, vref/1024 steps
   input  wire logic [11:0] level_req,
   // analog and fuse side
   output logic      [11:0] afe_sample,
   output logic      [7:0]  fuse_gain_cal,
   output logic      [7:0]  fuse_offset_cal
);
   // the front end settles one clock after a change of input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         afe_sample <= 12'h000;
      end else begin
         afe_sample <= level_req;
      end
   end
   // calibration values are arbitrary; offset chosen negative on purpose
   assign fuse_gain_cal   = GAIN_CAL;
   assign fuse_offset_cal = OFFS_CAL;
endmodule : arc_afe_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "arc_params.svh"
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000, smp = 12'h000, afe;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic        pready, pslverr, rerr, oe, v1, tsel;
   logic [1:0]  lvl;
   logic [7:0]  gcal, ocal;
   int          n_mismatch = 0, n_tests = 0, seed = 32'h18b3, k;
   always #10 pclk = ~pclk;
   arc_afe_model fe (.pclk(pclk), .presetn(presetn), .level_req(smp), .afe_sample(afe),
                     .fuse_gain_cal(gcal), .fuse_offset_cal(ocal));
   arc_result_ctrl #(.CONV_CYCLES(13)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .afe_sample(afe), .fuse_gain_cal(gcal),
      .fuse_offset_cal(ocal), .ref_output_pin_oe(oe), .ref_output_level(lvl),
      .temp_sensor_sel(tsel), .ref_internal_1v1(v1));
   // ----------------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------------
   task complete_run;
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   // ----------------------------------------------------------------
   // expected coding
   // ----------------------------------------------------------------
   function automatic logic [9:0] exp_code(input logic [4:0] ch, input logic bip,
                                           input logic signed [11:0] s);
      int v;
      v = s;
      if (ch[4]) begin
         v = v * (ch[0] ? 20 : 8);
         if (bip) begin
            v = v >>> 1;
            if (v > 511) v = 511;
            if (v < -512) v = -512;
            return v[9:0];
         end
      end
      if (v > 1023) v = 1023;
      if (v < 0) v = 0;
      return v[9:0];
   endfunction : exp_code
   // software's temperature formula on a 10-bit code and the two calibration bytes
   function automatic int celsius(input int code, input logic [7:0] g,
                                  input logic [7:0] o);
      return ((code - (298 - int'($signed(o)))) * 128) / int'(g) + 25;
   endfunction : celsius
   task convert(input logic [4:0] ch, input logic bip, input logic [11:0] s);
      logic [9:0] e;
      e = exp_code(ch, bip, s);
      smp <= s;
      wr(`ARC_OFF_CHREF, {24'h0000_00, 2'b01, 1'b0, ch});
      wr(`ARC_OFF_CTRL_A, 32'h0000_0080);
      wr(`ARC_OFF_CTRL_A, 32'h0000_00C0);
      k = 0;
      do begin
         rd(`ARC_OFF_CTRL_A);
         k++;
      end while (rdat[`ARC_CTRLA_DONE] !== 1'b1 && k < 60);
      chk({31'h0, rdat[`ARC_CTRLA_DONE]}, 32'h0000_0001);
      rd(`ARC_OFF_RESULT_LOW);
      chk(rdat, {24'h0000_00, e[7:0]});
      rd(`ARC_OFF_RESULT_HIGH);
      chk(rdat, {30'h0, e[9:8]});
      smp <= ~s;
      repeat (6) @(posedge pclk);
      rd(`ARC_OFF_RESULT_LOW);
      chk(rdat, {24'h0000_00, e[7:0]});
      wr(`ARC_OFF_CTRL_A, 32'h0000_0090);
   endtask : convert
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      #(20 * 20000);
      n_mismatch++;
      complete_run;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ARC_OFF_RESULT_HIGH);
      chk(rdat, 32'h0000_0000);
      rd(12'h0FC);
      chk({31'h0, rerr}, 32'h0000_0001);
      // signature bytes: address first, then data
      wr(`ARC_OFF_SIG_ADDR, {16'h0000, `ARC_SIG_GAIN_ADDR});
      rd(`ARC_OFF_SIG_DATA);
      chk(rdat, {24'h0000_00, fe.GAIN_CAL});
      wr(`ARC_OFF_SIG_ADDR, {16'h0000, `ARC_SIG_OFFS_ADDR});
      rd(`ARC_OFF_SIG_DATA);
      chk(rdat, {24'h0000_00, fe.OFFS_CAL});
      // unipolar is the default: no write to ctrl B before these
      convert(5'h10, 1'b0, -12'sd5);
      convert(5'h12, 1'b0, 12'd127);
      convert(5'h13, 1'b0, 12'd52);
      // left adjust of 0x3FF: high byte 0xFF, low byte 0xC0
      wr(`ARC_OFF_CHREF, 32'h0000_0073);
      rd(`ARC_OFF_RESULT_HIGH);
      chk(rdat, 32'h0000_00FF);
      rd(`ARC_OFF_RESULT_LOW);
      chk(rdat, 32'h0000_00C0);
      convert(5'h11, 1'b0, 12'h7FF);
      convert(5'h00, 1'b0, 12'h3FF);
      convert(5'h01, 1'b0, 12'h400);
      convert(5'h02, 1'b0, 12'hFFF);
      // temperature reading through the software formula
      convert(`ARC_CH_TEMP, 1'b0, 12'h144);
      rd(`ARC_OFF_RESULT_LOW);
      k = rdat;
      rd(`ARC_OFF_RESULT_HIGH);
      chk(celsius({rdat[1:0], k[7:0]}, gcal, ocal), celsius(324, 8'h7a, 8'hf3));
      for (int i = 0; i < 8; i++)
         convert($random(seed), 1'b0, $random(seed) % 700);
      wr(`ARC_OFF_CTRL_B, 32'h0000_0080);
      convert(5'h11, 1'b1, 12'd25);
      convert(5'h15, 1'b1, -12'sd52);
      convert(5'h17, 1'b1, 12'h800);
      convert(5'h1C, 1'b1, 12'd127);
      for (int i = 0; i < 8; i++)
         convert({1'b1, 4'($random(seed))}, 1'b1, $random(seed) % 80);
      // temperature channel on the internal 1.1 V reference
      wr(`ARC_OFF_CHREF, 32'h0000_004B);
      repeat (3) @(posedge pclk);
      chk({30'h0, tsel, v1}, 32'h0000_0003);
      // reference output: enable, converter on, select and ext-ref swept
      // the bench side never drives or pulls the pin
      for (int m = 0; m < 32; m++) begin
         wr(`ARC_OFF_MISC, {30'h0, m[0], m[1]});
         wr(`ARC_OFF_CHREF, {24'h0000_00, m[3:2], 6'h0B});
         wr(`ARC_OFF_CTRL_A, {24'h0000_00, m[4], 7'h00});
         repeat (3) @(posedge pclk);
         chk({31'h0, oe}, {31'h0, m[0] & m[4] & m[2] & !m[1]});
         chk({30'h0, lvl}, {30'h0, m[3:2]});
         chk({31'h0, v1}, {31'h0, m[3:2] == 2'b01 && !m[1]});
      end
      complete_run;
   end
endmodule : testbench
